// *** hdl/misc_cfg_pkg.sv ***
// Constants for the miscellaneous configuration register bank.
// Assumes a byte-addressed configuration space with 32-bit aligned words.
package misc_cfg_pkg;
   localparam logic [7:0]  MISC_CFG_OFFSET      = 8'hf0;
   localparam logic [7:0]  PM_CAP_OFFSET        = 8'h46;
   localparam logic [31:0] MISC_CFG_RESET       = 32'h0000_0000;
   localparam logic [31:0] MISC_CFG_WR_MASK     = 32'h0000_801f;
   localparam logic [31:0] ALL_ONES_DATA        = 32'hffff_ffff;
   localparam int          COLD_SUPPORT_BIT     = 15;
   localparam int          PM_CAP_COLD_BIT      = 15;
   localparam int          NO_TGT_ABORT_BIT     = 4;
   localparam int          PIN_ROUTE_BIT        = 3;
   localparam int          LINK_GATE_BYP_BIT    = 2;
   localparam int          HOST_GATE_BYP_BIT    = 1;
   localparam int          KEEP_HOST_CLK_BIT    = 0;
   localparam int          SYNC_STAGES          = 2;
endpackage : misc_cfg_pkg

// *** hdl/misc_config_register.sv ***
// Miscellaneous configuration register and the logic its bits steer.
// Assumes a configuration target that hands over single-cycle read/write
// strobes on clk, and link-domain status arriving from another clock.
//
// Behaviour
// - Register sits at offset F0h and resets to all zeros.
// - Bits 31 to 16 read zero and ignore writes.
// - Bits 14 to 5 read zero.
// - Bit 15 drives the cold power-event bit of the capabilities register.
// - Bit 4 clear: access to stopped link domain ends in target abort.
// - Bit 4 set: such access completes normally returning all-ones data.
// - Link logic splits into host and link clock domains; stopped domain inactive.
// - Bit 3 set routes general pin 3 to serial clock, pin 2 to data.
// - Bit 3 set puts general pin 3 and 2 drivers in high impedance.
// - Bit 2 set bypasses link clock gating.
// - Bit 1 set bypasses host clock gating.
// - Bit 0 set always requests the host clock keeps running.
// - Bit 0 clear lets the host clock stop through clock-run.
`timescale 1ns/1ps
module misc_config_register
   import misc_cfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_rack,
   output logic             pm_cap_cold_support,
   input  wire logic        link_access,
   input  wire logic        link_domain_active,
   output logic             link_target_abort,
   output logic             link_ones_complete,
   output logic             link_pass,
   output logic [31:0]      link_fill_data,
   input  wire logic        gpin3_in,
   input  wire logic        gpin2_in,
   input  wire logic        general_pin_3_out_req,
   input  wire logic        general_pin_2_out_req,
   input  wire logic        general_pin_3_drive_req,
   input  wire logic        general_pin_2_drive_req,
   output logic             gpin3_out,
   output logic             gpin3_oe_n,
   output logic             gpin2_out,
   output logic             gpin2_oe_n,
   output logic             general_pin_3_level,
   output logic             general_pin_2_level,
   output logic             two_wire_scl_in,
   output logic             two_wire_sda_in,
   output logic             link_clock_gate_bypass,
   output logic             host_clock_gate_bypass,
   input  wire logic        host_idle,
   output logic             host_clock_keep_req
);

   logic [31:0] misc_r;
   logic [31:0] misc_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        rack_r;
   logic        rack_nxt;
   logic        hit;
   logic [31:0] be_mask;

   // Byte enables expand to a bit mask for the write merge
   function automatic logic [31:0] expand_be(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction : expand_be

   assign hit     = (cfg_addr == MISC_CFG_OFFSET);
   assign be_mask = expand_be(cfg_be) & MISC_CFG_WR_MASK;

   always_comb
   begin
      misc_nxt  = misc_r;
      rdata_nxt = 32'h0000_0000;
      rack_nxt  = cfg_rd;
      if (cfg_wr && hit)
      begin
         misc_nxt = (misc_r & ~be_mask) | (cfg_wdata & be_mask);
      end
      if (cfg_rd && hit)
      begin
         rdata_nxt = misc_r & MISC_CFG_WR_MASK;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         misc_r  <= MISC_CFG_RESET;
         rdata_r <= 32'h0000_0000;
         rack_r  <= 1'b0;
      end
      else
      begin
         misc_r  <= misc_nxt;
         rdata_r <= rdata_nxt;
         rack_r  <= rack_nxt;
      end
   end

   assign cfg_rdata = rdata_r;
   assign cfg_rack  = rack_r;

   // Link activity comes from the link clock domain, so it is resynchronised
   logic [SYNC_STAGES-1:0] act_sync_r;
   logic [SYNC_STAGES-1:0] pin_sync3_r;
   logic [SYNC_STAGES-1:0] pin_sync2_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         act_sync_r  <= '0;
         pin_sync3_r <= '1;
         pin_sync2_r <= '1;
      end
      else
      begin
         act_sync_r  <= {act_sync_r[0], link_domain_active};
         pin_sync3_r <= {pin_sync3_r[0], gpin3_in};
         pin_sync2_r <= {pin_sync2_r[0], gpin2_in};
      end
   end

   logic        link_up;
   logic        no_abort;
   logic        route;
   logic        abort_nxt;
   logic        ones_nxt;
   logic        pass_nxt;
   logic [31:0] fill_nxt;
   logic        abort_r;
   logic        ones_r;
   logic        pass_r;
   logic [31:0] fill_r;
   logic        p3_out_nxt;
   logic        p3_oe_n_nxt;
   logic        p2_out_nxt;
   logic        p2_oe_n_nxt;
   logic        keep_nxt;
   logic [9:0]  pin_r;

   assign link_up  = act_sync_r[SYNC_STAGES-1];
   assign no_abort = misc_r[NO_TGT_ABORT_BIT];
   assign route    = misc_r[PIN_ROUTE_BIT];

   always_comb
   begin
      abort_nxt   = 1'b0;
      ones_nxt    = 1'b0;
      pass_nxt    = 1'b0;
      fill_nxt    = 32'h0000_0000;
      if (link_access)
      begin
         if (link_up)
         begin
            pass_nxt = 1'b1;
         end
         else if (no_abort)
         begin
            ones_nxt = 1'b1;
            fill_nxt = ALL_ONES_DATA;
         end
         else
         begin
            abort_nxt = 1'b1;
         end
      end
      // Routed pins float so the external two-wire pull-ups own the wire
      p3_out_nxt  = route ? 1'b0 : general_pin_3_out_req;
      p3_oe_n_nxt = route ? 1'b1 : ~general_pin_3_drive_req;
      p2_out_nxt  = route ? 1'b0 : general_pin_2_out_req;
      p2_oe_n_nxt = route ? 1'b1 : ~general_pin_2_drive_req;
      // Clock-run keeps the clock while busy even with bit 0 clear
      keep_nxt    = misc_r[KEEP_HOST_CLK_BIT] | ~host_idle;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         abort_r <= 1'b0;
         ones_r  <= 1'b0;
         pass_r  <= 1'b0;
         fill_r  <= 32'h0000_0000;
         pin_r   <= 10'h000;
      end
      else
      begin
         abort_r <= abort_nxt;
         ones_r  <= ones_nxt;
         pass_r  <= pass_nxt;
         fill_r  <= fill_nxt;
         pin_r   <= {misc_r[COLD_SUPPORT_BIT],
                     p3_out_nxt, p3_oe_n_nxt, p2_out_nxt, p2_oe_n_nxt,
                     misc_r[LINK_GATE_BYP_BIT],
                     misc_r[HOST_GATE_BYP_BIT],
                     keep_nxt,
                     route & pin_sync3_r[SYNC_STAGES-1],
                     route & pin_sync2_r[SYNC_STAGES-1]};
      end
   end

   logic gp_in3_r;
   logic gp_in2_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         gp_in3_r <= 1'b0;
         gp_in2_r <= 1'b0;
      end
      else
      begin
         gp_in3_r <= ~route & pin_sync3_r[SYNC_STAGES-1];
         gp_in2_r <= ~route & pin_sync2_r[SYNC_STAGES-1];
      end
   end

   assign link_target_abort      = abort_r;
   assign link_ones_complete     = ones_r;
   assign link_pass              = pass_r;
   assign link_fill_data         = fill_r;
   assign pm_cap_cold_support    = pin_r[9];
   assign gpin3_out              = pin_r[8];
   assign gpin3_oe_n             = pin_r[7];
   assign gpin2_out              = pin_r[6];
   assign gpin2_oe_n             = pin_r[5];
   assign link_clock_gate_bypass = pin_r[4];
   assign host_clock_gate_bypass = pin_r[3];
   assign host_clock_keep_req    = pin_r[2];
   assign two_wire_scl_in        = pin_r[1];
   assign two_wire_sda_in        = pin_r[0];
   assign general_pin_3_level    = gp_in3_r;
   assign general_pin_2_level    = gp_in2_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_reset_zero;
      $rose(rst_n) |-> (misc_r == MISC_CFG_RESET);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value not zero");

   property p_upper_zero;
      cfg_rack |-> (cfg_rdata[31:16] == 16'h0000);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

   property p_mid_zero;
      cfg_rack |-> (cfg_rdata[14:5] == 10'h000);
   endproperty
   a_mid_zero: assert property (p_mid_zero) else $error("reserved bits not zero");

   property p_cold_mirror;
      (cfg_wr && hit && cfg_be[1]) |-> ##2 (pm_cap_cold_support == $past(cfg_wdata[15], 2));
   endproperty
   a_cold_mirror: assert property (p_cold_mirror) else $error("cold bit not mirrored");

   property p_abort;
      (link_access && !link_up && !no_abort) |=> link_target_abort && !link_ones_complete;
   endproperty
   a_abort: assert property (p_abort) else $error("missing target abort");

   property p_ones;
      (link_access && !link_up && no_abort) |=>
         link_ones_complete && !link_target_abort && (link_fill_data == ALL_ONES_DATA);
   endproperty
   a_ones: assert property (p_ones) else $error("missing all-ones completion");

   property p_hiz;
      route |=> (gpin3_oe_n && gpin2_oe_n);
   endproperty
   a_hiz: assert property (p_hiz) else $error("routed pins driven");

   property p_keep;
      misc_r[KEEP_HOST_CLK_BIT] |=> host_clock_keep_req;
   endproperty
   a_keep: assert property (p_keep) else $error("clock keep not requested");

   property p_release;
      (!misc_r[KEEP_HOST_CLK_BIT] && host_idle) |=> !host_clock_keep_req;
   endproperty
   a_release: assert property (p_release) else $error("clock stop blocked");

   property p_bypass;
      ##1 (link_clock_gate_bypass == $past(misc_r[LINK_GATE_BYP_BIT]))
         && (host_clock_gate_bypass == $past(misc_r[HOST_GATE_BYP_BIT]));
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not following");

   property p_write_effect;
      (cfg_wr && hit && cfg_be[0]) |=> (misc_r[4:0] == $past(cfg_wdata[4:0]));
   endproperty
   a_write_effect: assert property (p_write_effect) else $error("write not taken");

   c_abort: cover property (link_access && !link_up && !no_abort);
   c_ones:  cover property (link_access && !link_up && no_abort);
   c_route: cover property (route && cfg_rack);

endmodule : misc_config_register

// *** tb/cfg_host_model.sv ***
// Host side model: issues configuration reads and writes one at a time.
// Assumes a free-running clk; strobes change only just after rising edges.
`timescale 1ns/1ps
module cfg_host_model
(
   input  wire logic        clk,
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic [7:0]       cfg_addr,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata,
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        cfg_rack
);
   initial
   begin
      cfg_wr    = 1'b0;
      cfg_rd    = 1'b0;
      cfg_addr  = 8'h00;
      cfg_be    = 4'h0;
      cfg_wdata = 32'h0;
   end

   // Released write data and read address are inverted so a stale value is never mistaken for a live one
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      cfg_wr    <= 1'b1;
      cfg_addr  <= a;
      cfg_be    <= be;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr    <= 1'b0;
      cfg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ack);
      @(posedge clk);
      cfg_rd   <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd   <= 1'b0;
      cfg_addr <= ~a;
      #1;
      d   = cfg_rdata;
      ack = cfg_rack;
   endtask : rd
endmodule : cfg_host_model

// *** tb/misc_config_register_test.sv ***
// Self-checking bench for the miscellaneous configuration register.
// Assumes the host model owns the config bus; the bench drives all other inputs.
`timescale 1ns/1ps
module misc_config_register_test;
   import misc_cfg_pkg::*;
   logic        clk, rst_n, cfg_wr, cfg_rd, cfg_rack, pm_cap_cold_support;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, link_fill_data, d;
   logic        link_access, link_domain_active, link_target_abort, link_ones_complete;
   logic        link_pass, gpin3_in, gpin2_in, gpin3_out, gpin3_oe_n, gpin2_out, gpin2_oe_n;
   logic        general_pin_3_out_req, general_pin_2_out_req, general_pin_3_drive_req;
   logic        general_pin_2_drive_req, general_pin_3_level, general_pin_2_level;
   logic        two_wire_scl_in, two_wire_sda_in, link_clock_gate_bypass;
   logic        host_clock_gate_bypass, host_idle, host_clock_keep_req, k;
   int          bad_count, n_checks;

   misc_config_register uut
   (
      .clk                     (clk),
      .rst_n                   (rst_n),
      .cfg_wr                  (cfg_wr),
      .cfg_rd                  (cfg_rd),
      .cfg_addr                (cfg_addr),
      .cfg_be                  (cfg_be),
      .cfg_wdata               (cfg_wdata),
      .cfg_rdata               (cfg_rdata),
      .cfg_rack                (cfg_rack),
      .pm_cap_cold_support     (pm_cap_cold_support),
      .link_access             (link_access),
      .link_domain_active      (link_domain_active),
      .link_target_abort       (link_target_abort),
      .link_ones_complete      (link_ones_complete),
      .link_pass               (link_pass),
      .link_fill_data          (link_fill_data),
      .gpin3_in                (gpin3_in),
      .gpin2_in                (gpin2_in),
      .general_pin_3_out_req   (general_pin_3_out_req),
      .general_pin_2_out_req   (general_pin_2_out_req),
      .general_pin_3_drive_req (general_pin_3_drive_req),
      .general_pin_2_drive_req (general_pin_2_drive_req),
      .gpin3_out               (gpin3_out),
      .gpin3_oe_n              (gpin3_oe_n),
      .gpin2_out               (gpin2_out),
      .gpin2_oe_n              (gpin2_oe_n),
      .general_pin_3_level     (general_pin_3_level),
      .general_pin_2_level     (general_pin_2_level),
      .two_wire_scl_in         (two_wire_scl_in),
      .two_wire_sda_in         (two_wire_sda_in),
      .link_clock_gate_bypass  (link_clock_gate_bypass),
      .host_clock_gate_bypass  (host_clock_gate_bypass),
      .host_idle               (host_idle),
      .host_clock_keep_req     (host_clock_keep_req)
   );

   cfg_host_model host
   (
      .clk       (clk),
      .cfg_wr    (cfg_wr),
      .cfg_rd    (cfg_rd),
      .cfg_addr  (cfg_addr),
      .cfg_be    (cfg_be),
      .cfg_wdata (cfg_wdata),
      .cfg_rdata (cfg_rdata),
      .cfg_rack  (cfg_rack)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      host.rd(a, d, k);
      chk("rack", {31'h0, k}, 32'h1);
      chk("rdata", d, exp);
   endtask : rdc

   // Covers the two-flop synchronisers plus the output register
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   task automatic ctl(input logic [3:0] e);
      chk("ctl", {28'h0, pm_cap_cold_support, link_clock_gate_bypass,
                  host_clock_gate_bypass, host_clock_keep_req}, {28'h0, e});
   endtask : ctl

   initial
   begin
      rst_n              = 1'b0;
      link_access        = 1'b0;
      link_domain_active = 1'b0;
      {gpin3_in, gpin2_in} = 2'h0;
      {general_pin_3_out_req, general_pin_2_out_req} = 2'h0;
      {general_pin_3_drive_req, general_pin_2_drive_req} = 2'h0;
      host_idle          = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rdc(MISC_CFG_OFFSET, MISC_CFG_RESET);
      ctl(4'h0);
      host.wr(MISC_CFG_OFFSET, 4'hf, ALL_ONES_DATA);
      rdc(MISC_CFG_OFFSET, 32'h0000_801f);
      settle();
      ctl(4'hf);
      rdc(8'hf4, 32'h0000_0000);
      host.wr(MISC_CFG_OFFSET, 4'he, 32'h0000_0000);
      rdc(MISC_CFG_OFFSET, 32'h0000_001f);
      host.wr(MISC_CFG_OFFSET, 4'h1, 32'h0000_8000);
      rdc(MISC_CFG_OFFSET, 32'h0000_0000);
      settle();
      ctl(4'h0);
      @(posedge clk);
      host_idle <= 1'b0;
      settle();
      ctl(4'h1);
      for (int i = 0; i < 4; i++)
      begin
         host.wr(MISC_CFG_OFFSET, 4'h1, {27'h0, i[1], 4'h0});
         @(posedge clk);
         link_domain_active <= i[0];
         settle();
         @(posedge clk);
         link_access <= 1'b1;
         @(posedge clk);
         link_access <= 1'b0;
         #1;
         chk("abort", {31'h0, link_target_abort}, {31'h0, ~i[0] & ~i[1]});
         chk("ones", {31'h0, link_ones_complete}, {31'h0, ~i[0] & i[1]});
         chk("pass", {31'h0, link_pass}, {31'h0, i[0]});
         chk("fill", link_fill_data, (~i[0] & i[1]) ? ALL_ONES_DATA : 32'h0);
      end
      // Pin 3 high and pin 2 low so a swapped route shows up
      for (int r = 0; r < 2; r++)
      begin
         host.wr(MISC_CFG_OFFSET, 4'h1, {28'h0, r[0], 3'h0});
         @(posedge clk);
         {gpin3_in, gpin2_in} <= 2'h2;
         {general_pin_3_out_req, general_pin_2_out_req} <= 2'h2;
         {general_pin_3_drive_req, general_pin_2_drive_req} <= 2'h3;
         settle();
         chk("pins", {24'h0, gpin3_out, gpin2_out, gpin3_oe_n, gpin2_oe_n, two_wire_scl_in,
                      two_wire_sda_in, general_pin_3_level, general_pin_2_level},
             r ? 32'h38 : 32'h82);
         rdc(MISC_CFG_OFFSET, {28'h0, r[0], 3'h0});
      end
      final_report();
   end

   initial
   begin
      #200000;
      bad_count++;
      final_report();
   end
endmodule : misc_config_register_test
